//--- verilog/onebit_monitor.sv
/*
 * Master clock prescaler, one-bit stream front end (normal and phase
 * modulated), static and invalid stream monitor, mute-control pins, APB
 * register file with sticky events and a level interrupt.
 * Assumes all inputs synchronous to clk; channel 0 is left, 1 is right.
 */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - halve enable divides master clock by two
// - third enable divides master clock by three
// - 28 identical bits mute converters when enabled
// - static mute drives mute pins, polarity applied
// - over 24 of 28 alike attenuates
// - invalid stream drives mute pins, polarity applied
// - phase modulation enable selects modulated reception
// - check control resets to static enabled only
// - polarity field: auto, active low, active high
module onebit_monitor (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        onebit_serial_clock,
    input  wire logic [1:0]  onebit_data,
    output var  logic [1:0]  converter_mute,
    output var  logic [1:0]  converter_attenuate,
    input  wire logic [1:0]  mute_control_in,
    output var  logic [1:0]  mute_control_out,
    output var  logic [1:0]  mute_control_oe,
    output var  logic        core_tick,
    output var  logic        divided_master_clock,
    output var  logic        irq
);
    // register state
    logic [1:0] prescale;        // {halve, third}
    logic [3:0] check_ctrl;
    logic [1:0] mute_polarity_field;
    logic [3:0] ev_status;
    logic [3:0] ev_mask;
    logic [3:0] hit_prev;
    logic [1:0] next_prescale;
    logic [3:0] next_check_ctrl;
    logic [1:0] next_mute_polarity_field;
    logic [3:0] next_ev_status;
    logic [3:0] next_ev_mask;
    logic [3:0] next_hit_prev;
    logic       next_irq;

    // apb state
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // prescaler state
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic       next_core_tick;
    logic       next_divided_master_clock;
    logic [2:0] divisor;

    // stream front end state
    logic                  sclk_prev;
    logic                  next_sclk_prev;
    monitor_pkg::pm_phase_t pm_phase;
    monitor_pkg::pm_phase_t next_pm_phase;
    logic                  bit_valid;
    logic                  next_bit_valid;
    logic [1:0]            bit_value;
    logic [1:0]            next_bit_value;

    // mute pin state
    logic       pol_caught;
    logic       auto_active_level;
    logic       next_pol_caught;
    logic       next_auto_active_level;
    logic [1:0] next_mute_control_out;
    logic [1:0] next_mute_control_oe;

    logic [1:0] static_hit;
    logic [1:0] invalid_hit;
    logic [3:0] hits;
    logic       access;
    logic       wr_en;
    logic       halve;
    logic       third;
    logic       pm_en;
    logic       pm_sel;
    logic       sclk_rise;

    function automatic logic reg_at(input logic [7:0] addr, input logic [5:0] idx);
        reg_at = addr[7:2] == idx && addr[1:0] == 2'h0;
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = reg_at(addr, monitor_pkg::IDX_PRESCALE)
                 || reg_at(addr, monitor_pkg::IDX_CHECK_CTRL)
                 || reg_at(addr, monitor_pkg::IDX_POLARITY)
                 || reg_at(addr, monitor_pkg::IDX_EV_STATUS)
                 || reg_at(addr, monitor_pkg::IDX_EV_MASK)
                 || reg_at(addr, monitor_pkg::IDX_LIVE_STATE);
    endfunction

    assign halve  = prescale[1];
    assign third  = prescale[0];
    assign pm_en  = check_ctrl[monitor_pkg::PM_EN_BIT];
    assign pm_sel = check_ctrl[monitor_pkg::PM_SEL_BIT];
    assign access = psel && penable;
    // write lands on the edge where the master sees pready high
    assign wr_en  = access && pready && pwrite && pstrb[0];
    assign hits   = {invalid_hit, static_hit};

    // prescaler: core_tick paces the serial clock sampling of the stream front end
    always_comb begin
        case ({halve, third})
            2'b10:   divisor = monitor_pkg::DIV_BY_TWO;
            2'b01:   divisor = monitor_pkg::DIV_BY_THREE;
            2'b11:   divisor = monitor_pkg::DIV_BY_SIX;
            default: divisor = monitor_pkg::DIV_BY_ONE;
        endcase
        // >= restarts cleanly when the divisor shrinks mid-count
        if (div_cnt >= divisor - 3'h1) begin
            next_div_cnt = 3'h0;
        end else begin
            next_div_cnt = div_cnt + 3'h1;
        end
        next_core_tick            = next_div_cnt == 3'h0;
        next_divided_master_clock = {next_div_cnt, 1'b0} < {1'b0, divisor};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt              <= 3'h0;
            core_tick            <= 1'b1;
            divided_master_clock <= 1'b1;
        end else begin
            div_cnt              <= next_div_cnt;
            core_tick            <= next_core_tick;
            divided_master_clock <= next_divided_master_clock;
        end
    end

    // stream front end: serial clock sampled at the divided rate only
    assign sclk_rise = core_tick && onebit_serial_clock && !sclk_prev;

    always_comb begin
        next_sclk_prev = core_tick ? onebit_serial_clock : sclk_prev;
        next_pm_phase  = pm_phase;
        next_bit_valid = 1'b0;
        next_bit_value = bit_value;
        if (!pm_en) begin
            next_pm_phase = monitor_pkg::PHASE_FIRST;
        end
        if (sclk_rise) begin
            if (pm_en && !pm_sel) begin
                // 128Fs clock: two edges per bit, data taken in first half
                case (pm_phase)
                    monitor_pkg::PHASE_FIRST: begin
                        next_pm_phase  = monitor_pkg::PHASE_SECOND;
                        next_bit_valid = 1'b1;
                        next_bit_value = onebit_data;
                    end
                    monitor_pkg::PHASE_SECOND: begin
                        next_pm_phase = monitor_pkg::PHASE_FIRST;
                    end
                    default: begin
                        next_pm_phase = monitor_pkg::PHASE_FIRST;
                    end
                endcase
            end else begin
                // normal mode, or 64Fs modulated clock: one bit per rise
                next_bit_valid = 1'b1;
                next_bit_value = onebit_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev <= 1'b0;
            pm_phase  <= monitor_pkg::PHASE_FIRST;
            bit_valid <= 1'b0;
            bit_value <= 2'h0;
        end else begin
            sclk_prev <= next_sclk_prev;
            pm_phase  <= next_pm_phase;
            bit_valid <= next_bit_valid;
            bit_value <= next_bit_value;
        end
    end

    // one independent checker per channel
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            stream_check_if chk_if ();
            assign chk_if.bit_valid  = bit_valid;
            assign chk_if.bit_value  = bit_value[ch];
            assign chk_if.static_en  = check_ctrl[monitor_pkg::STATIC_BIT];
            assign chk_if.invalid_en = check_ctrl[monitor_pkg::INVALID_BIT];
            assign static_hit[ch]    = chk_if.static_hit;
            assign invalid_hit[ch]   = chk_if.invalid_hit;
            density_checker u_check (
                .clk   (clk),
                .rst_n (rst_n),
                .chk   (chk_if.checker_end)
            );
        end
    endgenerate

    // converter controls and mute pins
    always_comb begin
        next_pol_caught        = 1'b1;
        // auto: pin is biased to its active level while undriven
        next_auto_active_level = pol_caught ? auto_active_level : mute_control_in[0];
        for (int ch = 0; ch < 2; ch++) begin
            case (mute_polarity_field)
                monitor_pkg::POL_LOW: begin
                    next_mute_control_out[ch] = !(static_hit[ch] || invalid_hit[ch]);
                end
                monitor_pkg::POL_HIGH: begin
                    next_mute_control_out[ch] = static_hit[ch] || invalid_hit[ch];
                end
                default: begin
                    next_mute_control_out[ch] = (static_hit[ch] || invalid_hit[ch])
                                              == next_auto_active_level;
                end
            endcase
        end
        next_mute_control_oe  = {2{next_pol_caught}};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_caught          <= 1'b0;
            auto_active_level   <= 1'b0;
            mute_control_out    <= 2'h0;
            mute_control_oe     <= 2'h0;
            converter_mute      <= 2'h0;
            converter_attenuate <= 2'h0;
        end else begin
            pol_caught          <= next_pol_caught;
            auto_active_level   <= next_auto_active_level;
            mute_control_out    <= next_mute_control_out;
            mute_control_oe     <= next_mute_control_oe;
            converter_mute      <= static_hit;
            converter_attenuate <= invalid_hit;
        end
    end

    // register file and apb slave, one wait state on every access
    always_comb begin
        next_prescale            = prescale;
        next_check_ctrl          = check_ctrl;
        next_mute_polarity_field = mute_polarity_field;
        next_ev_mask             = ev_mask;
        next_hit_prev            = hits;
        next_ev_status           = ev_status;
        if (wr_en && reg_at(paddr, monitor_pkg::IDX_PRESCALE)) begin
            next_prescale = {pwdata[monitor_pkg::HALVE_BIT], pwdata[monitor_pkg::THIRD_BIT]};
        end
        if (wr_en && reg_at(paddr, monitor_pkg::IDX_CHECK_CTRL)) begin
            next_check_ctrl = pwdata[3:0] & monitor_pkg::CHECK_CTRL_WMASK[3:0];
        end
        if (wr_en && reg_at(paddr, monitor_pkg::IDX_POLARITY)) begin
            next_mute_polarity_field = pwdata[1:0];
        end
        if (wr_en && reg_at(paddr, monitor_pkg::IDX_EV_MASK)) begin
            next_ev_mask = pwdata[3:0];
        end
        if (wr_en && reg_at(paddr, monitor_pkg::IDX_EV_STATUS)) begin
            next_ev_status = ev_status & ~pwdata[3:0];
        end
        // a new event wins over a clear in the same cycle
        next_ev_status = next_ev_status | (hits & ~hit_prev);
        next_irq       = |(next_ev_status & next_ev_mask);

        next_pready  = access && !pready;
        next_pslverr = access && !pready && !is_mapped(paddr);
        next_prdata  = 32'h0000_0000;
        if (access && !pready && !pwrite) begin
            if (reg_at(paddr, monitor_pkg::IDX_PRESCALE)) begin
                next_prdata[monitor_pkg::HALVE_BIT] = halve;
                next_prdata[monitor_pkg::THIRD_BIT] = third;
            end
            if (reg_at(paddr, monitor_pkg::IDX_CHECK_CTRL)) begin
                next_prdata[3:0] = check_ctrl; // upper four read as zero
            end
            if (reg_at(paddr, monitor_pkg::IDX_POLARITY)) begin
                next_prdata[1:0] = mute_polarity_field;
            end
            if (reg_at(paddr, monitor_pkg::IDX_EV_STATUS)) begin
                next_prdata[3:0] = ev_status;
            end
            if (reg_at(paddr, monitor_pkg::IDX_EV_MASK)) begin
                next_prdata[3:0] = ev_mask;
            end
            if (reg_at(paddr, monitor_pkg::IDX_LIVE_STATE)) begin
                next_prdata[5:0] = {auto_active_level, pm_phase, hits};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale            <= 2'h0;
            check_ctrl          <= monitor_pkg::CHECK_CTRL_RESET[3:0];
            mute_polarity_field <= monitor_pkg::POL_RESET;
            ev_status           <= 4'h0;
            ev_mask             <= monitor_pkg::EV_MASK_RESET;
            hit_prev            <= 4'h0;
            irq                 <= 1'b0;
            prdata              <= 32'h0000_0000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
        end else begin
            prescale            <= next_prescale;
            check_ctrl          <= next_check_ctrl;
            mute_polarity_field <= next_mute_polarity_field;
            ev_status           <= next_ev_status;
            ev_mask             <= next_ev_mask;
            hit_prev            <= next_hit_prev;
            irq                 <= next_irq;
            prdata              <= next_prdata;
            pready              <= next_pready;
            pslverr             <= next_pslverr;
        end
    end
endmodule // onebit_monitor

`default_nettype wire

//--- pkg/monitor_pkg.sv
/*
 * Constants for the master clock prescaler and one-bit stream monitor:
 * register indices, field positions, reset values, detector limits and states.
 * Assumes a 32-bit APB with word-aligned registers (byte address = index * 4).
 */
package monitor_pkg;

    // register indices; byte address is the index shifted left by two
    localparam logic [5:0] IDX_PRESCALE   = 6'h08;
    localparam logic [5:0] IDX_CHECK_CTRL = 6'h09;
    localparam logic [5:0] IDX_POLARITY   = 6'h0A;
    localparam logic [5:0] IDX_EV_STATUS  = 6'h0B;
    localparam logic [5:0] IDX_EV_MASK    = 6'h0C;
    localparam logic [5:0] IDX_LIVE_STATE = 6'h0D;

    // clock prescale control fields
    localparam int HALVE_BIT = 4;
    localparam int THIRD_BIT = 3;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    // stream check control fields
    localparam int STATIC_BIT  = 3;
    localparam int INVALID_BIT = 2;
    localparam int PM_SEL_BIT  = 1;
    localparam int PM_EN_BIT   = 0;
    localparam logic [7:0] CHECK_CTRL_RESET = 8'h08;
    localparam logic [7:0] CHECK_CTRL_WMASK = 8'h0F;

    // mute polarity codes, field in bits 1:0
    localparam logic [1:0] POL_AUTO  = 2'h0;
    localparam logic [1:0] POL_LOW   = 2'h2;
    localparam logic [1:0] POL_HIGH  = 2'h3;
    localparam logic [1:0] POL_RESET = 2'h0;

    // event layout: bits 1:0 static per channel, bits 3:2 invalid per channel
    localparam int EV_STATIC_LSB  = 0;
    localparam int EV_INVALID_LSB = 2;
    localparam logic [3:0] EV_MASK_RESET = 4'h0;

    // prescaler divisors
    localparam logic [2:0] DIV_BY_ONE   = 3'h1;
    localparam logic [2:0] DIV_BY_TWO   = 3'h2;
    localparam logic [2:0] DIV_BY_THREE = 3'h3;
    localparam logic [2:0] DIV_BY_SIX   = 3'h6;

    // stream detector figures
    localparam int         WINDOW_BITS   = 28;
    localparam logic [4:0] RUN_LIMIT     = 5'h1C;
    localparam logic [4:0] DENSITY_LIMIT = 5'h18;

    typedef enum logic [0:0] {
        PHASE_FIRST  = 1'b0,
        PHASE_SECOND = 1'b1
    } pm_phase_t;

endpackage

//--- pkg/stream_check_if.sv
/*
 * Bundle between the stream front end and one per-channel pattern checker.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/10ps
`default_nettype none

interface stream_check_if;
    logic bit_valid;
    logic bit_value;
    logic static_en;
    logic invalid_en;
    logic static_hit;
    logic invalid_hit;

    modport feeder (
        output bit_valid,
        output bit_value,
        output static_en,
        output invalid_en,
        input  static_hit,
        input  invalid_hit
    );

    modport checker_end (
        input  bit_valid,
        input  bit_value,
        input  static_en,
        input  invalid_en,
        output static_hit,
        output invalid_hit
    );
endinterface // stream_check_if

`default_nettype wire

//--- verilog/density_checker.sv
/*
 * Per-channel one-bit stream checker: run length of identical bits and
 * ones density over a sliding window of the last 28 bits.
 * Assumes bit_valid is a one-cycle strobe per decoded stream bit.
 */
`timescale 1ns/10ps
`default_nettype none

module density_checker (
    input  wire logic               clk,
    input  wire logic               rst_n,
    stream_check_if.checker_end     chk
);
    localparam int WB = monitor_pkg::WINDOW_BITS;

    logic [WB-1:0] window;
    logic [4:0]    fill;
    logic [4:0]    ones;
    logic [4:0]    run_len;
    logic          last_bit;
    logic          static_hit;
    logic          invalid_hit;

    logic [WB-1:0] next_window;
    logic [4:0]    next_fill;
    logic [4:0]    next_ones;
    logic [4:0]    next_run_len;
    logic          next_last_bit;
    logic          next_static_hit;
    logic          next_invalid_hit;

    always_comb begin
        next_window   = window;
        next_fill     = fill;
        next_ones     = ones;
        next_run_len  = run_len;
        next_last_bit = last_bit;
        if (chk.bit_valid) begin
            next_window   = {window[WB-2:0], chk.bit_value};
            next_last_bit = chk.bit_value;
            // run restarts at one on every change of value
            if (chk.bit_value != last_bit || run_len == 5'h00) begin
                next_run_len = 5'h01;
            end else if (run_len < monitor_pkg::RUN_LIMIT) begin
                next_run_len = run_len + 5'h01;
            end
            if (fill == monitor_pkg::RUN_LIMIT) begin
                next_ones = ones + {4'h0, chk.bit_value} - {4'h0, window[WB-1]};
            end else begin
                next_fill = fill + 5'h01;
                next_ones = ones + {4'h0, chk.bit_value};
            end
        end
        next_static_hit = chk.static_en
                        && next_run_len == monitor_pkg::RUN_LIMIT;
        // more than 24 of 28 alike: ones above 24 or zeros above 24
        next_invalid_hit = chk.invalid_en
                         && next_fill == monitor_pkg::RUN_LIMIT
                         && (next_ones > monitor_pkg::DENSITY_LIMIT
                             || next_ones < monitor_pkg::RUN_LIMIT
                                            - monitor_pkg::DENSITY_LIMIT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window      <= '0;
            fill        <= 5'h00;
            ones        <= 5'h00;
            run_len     <= 5'h00;
            last_bit    <= 1'b0;
            static_hit  <= 1'b0;
            invalid_hit <= 1'b0;
        end else begin
            window      <= next_window;
            fill        <= next_fill;
            ones        <= next_ones;
            run_len     <= next_run_len;
            last_bit    <= next_last_bit;
            static_hit  <= next_static_hit;
            invalid_hit <= next_invalid_hit;
        end
    end

    assign chk.static_hit  = static_hit;
    assign chk.invalid_hit = invalid_hit;
endmodule // density_checker

`default_nettype wire

//--- testbench/onebit_monitor_chk.sv
/* Port checker for onebit_monitor: APB answer timing, mute pins, prescaler tick.
   Assumes one clock domain; bound into every onebit_monitor instance. */
`timescale 1ns/10ps
`default_nettype none
module onebit_monitor_chk (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [1:0]  converter_mute,
    input  wire logic [1:0]  converter_attenuate,
    input  wire logic [1:0]  mute_control_out,
    input  wire logic [1:0]  mute_control_oe,
    input  wire logic        core_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence setup_then_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // slowest prescale is divide by six
    sequence tick_soon;
        ##[1:6] core_tick;
    endsequence
    chk_ready_timing: assert property (setup_then_access |=> pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_early: assert property ($rose(penable) |-> !pready)
        else $error("pready in first access cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    chk_err_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside answer");
    chk_oe_driven: assert property ($past(rst_n) |-> mute_control_oe == 2'h3)
        else $error("mute pins not driven after reset");
    chk_tick_gap: assert property (core_tick |-> tick_soon)
        else $error("core tick gap too long");
    chk_mute_pin: assert property ($rose(converter_mute[0]) && !converter_attenuate[0]
        && $past(!converter_attenuate[0]) |-> mute_control_out[0] != $past(mute_control_out[0]))
        else $error("static mute left pin unchanged");
    chk_atten_pin: assert property ($rose(converter_attenuate[0]) && !converter_mute[0]
        && $past(!converter_mute[0]) |-> mute_control_out[0] != $past(mute_control_out[0]))
        else $error("invalid stream left pin unchanged");
endmodule // onebit_monitor_chk
bind onebit_monitor onebit_monitor_chk u_chk (.clk, .rst_n, .psel, .penable, .prdata,
    .pready, .pslverr, .converter_mute, .converter_attenuate, .mute_control_out,
    .mute_control_oe, .core_tick);
`default_nettype wire

//--- testbench/onebit_source.sv
/* One-bit stream source: serial clock and left/right data lines.
   Assumes clk is the bench clock; serial clock stands low between bits. */
`timescale 1ns/10ps
`default_nettype none
module onebit_source (
    input  wire logic       clk,
    output var  logic       sclk,
    output var  logic [1:0] data
);
    initial begin
        sclk = 1'b0;
        data = 2'h0;
    end
    // slow stretches both clock phases, standing in for the slower rate
    task automatic send(input logic [1:0] b, input int slow);
        @(posedge clk);
        data <= b;
        repeat (slow) @(posedge clk);
        sclk <= 1'b1;
        repeat (slow) @(posedge clk);
        sclk <= 1'b0;
        data <= ~b; // hold over: no stale level left on the lines
    endtask
endmodule // onebit_source
`default_nettype wire

//--- testbench/onebit_monitor_tb.sv
/* Self-checking bench for onebit_monitor: registers, prescaler, stream checks.
   Assumes onebit_source as stream partner and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
module onebit_monitor_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic [1:0]  sdata;
    logic [1:0]  converter_mute;
    logic [1:0]  converter_attenuate;
    logic [1:0]  mute_control_out;
    logic [1:0]  mute_control_oe;
    logic [1:0]  mute_pin;
    logic        core_tick;
    logic        mclk_div;
    logic        irq;
    logic [31:0] seed = 32'h781C0FA5;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    int          ticks[4] = '{12, 4, 6, 2};
    int          cnt;
    int          err_count = 0;
    int          num_checks = 0;

    always #5 clk = ~clk;
    // undriven pins are biased low, so auto polarity reads active low
    assign mute_pin = mute_control_out & mute_control_oe;

    onebit_monitor dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .onebit_serial_clock(sclk),
        .onebit_data(sdata), .converter_mute, .converter_attenuate,
        .mute_control_in(mute_pin), .mute_control_out, .mute_control_oe, .core_tick,
        .divided_master_clock(mclk_div), .irq);
    onebit_source src (.clk, .sclk, .data(sdata));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (!pwrite)
                check("prdata", prdata, note[31:0]);
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic e);
        @(posedge clk);
        exp_q.push_back({e, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic bits(input logic [63:0] w0, w1, input int n, slow);
        for (int i = 0; i < n; i++)
            src.send({w1[i], w0[i]}, slow);
    endtask

    // outputs land three cycles after the rise; four leaves margin
    task automatic look(input logic [1:0] mute, att, pins);
        repeat (4) @(posedge clk);
        #1;
        check("converter_mute", {30'h0, converter_mute}, {30'h0, mute});
        check("converter_attenuate", {30'h0, converter_attenuate}, {30'h0, att});
        check("mute_control_out", {30'h0, mute_control_out}, {30'h0, pins});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        look(2'h0, 2'h0, 2'h3);
        apb(1'b0, 8'h24, 32'h08, 1'b0);
        apb(1'b0, 8'h20, 32'h00, 1'b0);
        apb(1'b0, 8'h28, 32'h00, 1'b0);
        apb(1'b0, 8'h3C, 32'h00, 1'b1);
        apb(1'b1, 8'h24, 32'hFF, 1'b0);
        apb(1'b0, 8'h24, 32'h0F, 1'b0);
        seed = xs(seed);
        apb(1'b1, 8'h30, seed, 1'b0);
        apb(1'b0, 8'h30, seed & 32'hF, 1'b0);
        apb(1'b1, 8'h30, 32'hF, 1'b0);
        apb(1'b1, 8'h24, 32'h08, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h20, 32'(i) << 3, 1'b0);
            repeat (3) @(posedge clk);
            cnt = 0;
            repeat (12) begin
                @(posedge clk);
                #1;
                cnt += int'(core_tick && mclk_div);
            end
            check("core_tick", cnt, ticks[i]);
        end
        apb(1'b1, 8'h20, 32'h00, 1'b0);
        apb(1'b1, 8'h28, 32'h3, 1'b0);
        look(2'h0, 2'h0, 2'h0);
        bits(64'h0, 64'h400, 28, 1);
        look(2'h1, 2'h0, 2'h1);
        check("irq", {31'h0, irq}, 32'h1);
        apb(1'b0, 8'h2C, 32'h1, 1'b0);
        bits(64'h0, 64'h0, 10, 1);
        look(2'h1, 2'h0, 2'h1);
        bits(64'h0, 64'h0, 1, 3);
        look(2'h3, 2'h0, 2'h3);
        apb(1'b1, 8'h2C, 32'h3, 1'b0);
        apb(1'b0, 8'h2C, 32'h0, 1'b0);
        check("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, 8'h28, 32'h2, 1'b0);
        look(2'h3, 2'h0, 2'h0);
        apb(1'b1, 8'h24, 32'h0, 1'b0);
        look(2'h0, 2'h0, 2'h3);
        bits(64'h5555555555555555, 64'h5555555555555555, 28, 3);
        apb(1'b1, 8'h24, 32'h4, 1'b0);
        bits(64'h0FFFFFF0, 64'h0FFFFFF0, 28, 1);
        look(2'h0, 2'h0, 2'h3);
        bits(64'h1, 64'h1, 1, 1);
        look(2'h0, 2'h3, 2'h0);
        apb(1'b1, 8'h24, 32'h0, 1'b0);
        bits(64'h0, 64'h0, 1, 1);
        apb(1'b1, 8'h24, 32'h09, 1'b0);
        bits('1, '1, 28, 1);
        look(2'h0, 2'h0, 2'h3);
        bits('1, '1, 28, 1);
        look(2'h3, 2'h0, 2'h0);
        apb(1'b1, 8'h24, 32'h0B, 1'b0);
        bits(64'h0, 64'h0, 28, 1);
        look(2'h3, 2'h0, 2'h0);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule // onebit_monitor_tb
`default_nettype wire
